// [src/attach_probe_timer_status_regs.sv]
// Purpose: attach probe control, probe counter and timer/thermal status registers
// Assumes: analog comparator and charger status inputs are synchronous to aclk
// Notes: long counts are parameters so a simulation can shorten them
//
// How it works
// - a written one on the probe start bit begins the probe and the bit drops itself when done.
// - sense select low gives the 100 mV low threshold with sense interrupt off, high gives 400 mV with it on.
// - rate select picks a 40 us counter step when low and 80 us when high.
// - a written one on the re-sample bit wakes the device for about 1 ms and refreshes the comparator bits.
// - the return to sleep after a re-sample raises an interrupt event.
// - the current sink bit reads one while the bus current sink is on.
// - during a probe with the current source on the 8-bit counter steps by one every 40 us by default.
// - the counter stops on a rising 700 mV comparator (probe done) or at 255 (probe error).
// - a host read of the counter returns the count and then clears it.
// - the no-battery flag reads one once a no-battery test has completed.
// - the long timer flag reads one once the thirty-minute timer has run out.
// - both of those flags clear while the bus supply is disconnected, except in a cycle that sets them.
// - the long timer disable bit keeps the thirty-minute timer from ever expiring.
// - the watchdog disable bit keeps the thirty-two-second timer from ever expiring.
// - the over-temperature bit mirrors the die comparator above 135 C.
// - two read-only bits show whether the charger is enabled and the regulator is on.
`timescale 1ns/1ps
`default_nettype none
module attach_probe_timer_status_regs #(
  parameter int unsigned RESAMPLE_CYCLES = attach_probe_pkg::RESAMPLE_CYCLES,
  parameter longint unsigned LONG_TIMER_CYCLES = attach_probe_pkg::LONG_TIMER_CYCLES,
  parameter longint unsigned WATCHDOG_CYCLES = attach_probe_pkg::WATCHDOG_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,

  input wire attach_probe_pkg::bus_compare_t bus_compare,
  input wire attach_probe_pkg::charger_status_t charger_status,
  input wire logic bus_connected,
  input wire logic no_battery_test_complete,
  input wire logic long_timer_run,
  input wire logic watchdog_kick,

  // to the analog side, plus the watchdog and interrupt outputs
  output logic probe_source_on,
  output logic low_thresh_400mv,
  output logic resample_awake,
  output logic watchdog_expired,
  output logic irq
);

  // write channel bookkeeping
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [7:0] w_data;
  logic w_lane0;
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire = s_axi_wvalid & s_axi_wready;
  wire wr_do = aw_got & w_got & ~s_axi_bvalid;
  wire wr_en = wr_do & w_lane0;
  wire wr_ctl = wr_en & (aw_addr == attach_probe_pkg::ADDR_PROBE_CONTROL);
  wire wr_ts = wr_en & (aw_addr == attach_probe_pkg::ADDR_TIMER_STATUS);
  wire wr_ist = wr_en & (aw_addr == attach_probe_pkg::ADDR_IRQ_STATUS);
  wire wr_msk = wr_en & (aw_addr == attach_probe_pkg::ADDR_IRQ_MASK);

  // unmapped: error answer
  wire wr_hit = (aw_addr == attach_probe_pkg::ADDR_PROBE_CONTROL) |
                (aw_addr == attach_probe_pkg::ADDR_PROBE_COUNT) |
                (aw_addr == attach_probe_pkg::ADDR_TIMER_STATUS) |
                (aw_addr == attach_probe_pkg::ADDR_IRQ_STATUS) |
                (aw_addr == attach_probe_pkg::ADDR_IRQ_MASK);

  // read channel decode
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  wire rd_count = ar_fire & (s_axi_araddr == attach_probe_pkg::ADDR_PROBE_COUNT);

  // register state
  attach_probe_pkg::probe_state_t state;
  attach_probe_pkg::probe_state_t next_state;
  logic sense_select;
  logic probe_rate_select;
  logic long_timer_disable;
  logic watchdog_disable;

  logic [3:0] bus_snapshot;
  logic [7:0] probe_counter;
  logic [7:0] next_counter;
  logic [11:0] tick_cnt;
  logic high_prev;
  logic low_prev;
  logic [31:0] resample_cnt;
  logic [39:0] long_cnt;
  logic [39:0] wd_cnt;
  logic no_battery_test_done;
  logic long_timer_expired;
  logic [attach_probe_pkg::IRQ_W-1:0] irq_status;
  logic [attach_probe_pkg::IRQ_W-1:0] irq_mask;
  logic [attach_probe_pkg::IRQ_W-1:0] irq_events;
  logic [3:0] status_mirror;

  // probe sequencing
  wire probing = (state == attach_probe_pkg::PROBE_RUN);
  wire start_req = wr_ctl & w_data[attach_probe_pkg::CTL_START];
  wire [11:0] tick_len = probe_rate_select ? attach_probe_pkg::TICK_SLOW_CYCLES :
                         attach_probe_pkg::TICK_FAST_CYCLES;
  wire tick = probing & (tick_cnt == tick_len - 12'h001);

  wire high_rise = bus_compare.bus_above_high_thresh & ~high_prev;
  wire probe_done = probing & high_rise;
  // done wins over error
  wire probe_error = probing & ~high_rise & (probe_counter == attach_probe_pkg::COUNT_MAX);
  wire count_step = tick & ~probe_done & ~probe_error;

  // resample wake window
  wire resample_req = wr_ctl & w_data[attach_probe_pkg::CTL_RESAMPLE];
  wire resample_end = resample_awake & (resample_cnt == 32'(RESAMPLE_CYCLES - 1));
  wire sense_rise = sense_select & bus_compare.bus_above_low_thresh & ~low_prev;

  // supervisory timers
  wire long_end = long_timer_run & ~long_timer_disable & ~long_timer_expired &
                  (long_cnt == 40'(LONG_TIMER_CYCLES - 1));
  // writes with byte lane 0 strobed count as kicks
  wire wd_restart = watchdog_kick | wr_en;
  wire wd_end = ~watchdog_disable & ~wd_restart &
                (wd_cnt == 40'(WATCHDOG_CYCLES - 1));

  always_comb begin
    next_state = state;
    case (state)
      attach_probe_pkg::PROBE_IDLE: begin
        if (start_req) begin
          next_state = attach_probe_pkg::PROBE_RUN;
        end
      end
      attach_probe_pkg::PROBE_RUN: begin
        if (probe_done | probe_error) begin
          next_state = attach_probe_pkg::PROBE_IDLE;
        end
      end
      default: begin
        next_state = attach_probe_pkg::PROBE_IDLE;
      end
    endcase
  end

  // a read clear that meets a step leaves one, so that step is not lost
  always_comb begin
    next_counter = probe_counter;
    if (rd_count) begin
      next_counter = count_step ? 8'h01 : 8'h00;
    end else if (count_step) begin
      next_counter = probe_counter + 8'h01;
    end else if (start_req & ~probing) begin
      next_counter = attach_probe_pkg::RST_COUNT;
    end
  end

  assign irq_events[attach_probe_pkg::IRQ_PROBE_DONE] = probe_done;
  assign irq_events[attach_probe_pkg::IRQ_PROBE_ERROR] = probe_error;
  assign irq_events[attach_probe_pkg::IRQ_RESAMPLE] = resample_end;
  assign irq_events[attach_probe_pkg::IRQ_SENSE] = sense_rise;
  assign irq_events[attach_probe_pkg::IRQ_LONG_TIMER] = long_end;
  assign irq_events[attach_probe_pkg::IRQ_WATCHDOG] = wd_end;

  // set wins over a write-one clear
  wire [attach_probe_pkg::IRQ_W-1:0] next_irq_status =
    (irq_status & ~(wr_ist ? w_data[attach_probe_pkg::IRQ_W-1:0] : 6'h00)) | irq_events;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= attach_probe_pkg::PROBE_IDLE;
      probe_counter <= attach_probe_pkg::RST_COUNT;
      tick_cnt <= 12'h000;
      high_prev <= 1'b0;
      low_prev <= 1'b0;
      probe_source_on <= 1'b0;
    end else begin
      state <= next_state;
      probe_counter <= next_counter;
      tick_cnt <= (tick | ~probing) ? 12'h000 : tick_cnt + 12'h001;
      high_prev <= bus_compare.bus_above_high_thresh;
      low_prev <= bus_compare.bus_above_low_thresh;
      probe_source_on <= (next_state == attach_probe_pkg::PROBE_RUN);
    end
  end

  // control bits written by software; status and reserved bits take no write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_select <= 1'b0;
      probe_rate_select <= 1'b0;
      long_timer_disable <= 1'b0;
      watchdog_disable <= 1'b0;
      low_thresh_400mv <= 1'b0;
      irq_mask <= attach_probe_pkg::RST_IRQ_MASK;
    end else begin
      if (wr_ctl) begin
        sense_select <= w_data[attach_probe_pkg::CTL_SENSE];
        probe_rate_select <= w_data[attach_probe_pkg::CTL_RATE];
        low_thresh_400mv <= w_data[attach_probe_pkg::CTL_SENSE];
      end
      if (wr_ts) begin
        long_timer_disable <= w_data[attach_probe_pkg::TS_LONG_DISABLE];
        watchdog_disable <= w_data[attach_probe_pkg::TS_WD_DISABLE];
      end
      if (wr_msk) begin
        irq_mask <= w_data[attach_probe_pkg::IRQ_W-1:0];
      end
    end
  end

  // comparator bits only refresh while awake or probing, as the real part sleeps otherwise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resample_awake <= 1'b0;
      resample_cnt <= 32'h0000_0000;
      bus_snapshot <= 4'h0;
    end else begin
      if (resample_req & ~resample_awake) begin
        resample_awake <= 1'b1;
        resample_cnt <= 32'h0000_0000;
      end else if (resample_end) begin
        resample_awake <= 1'b0;
      end else if (resample_awake) begin
        resample_cnt <= resample_cnt + 32'h0000_0001;
      end
      if (resample_awake | probing) begin
        bus_snapshot <= {bus_compare.bus_sink_on, bus_compare.bus_ref_compare,
                         bus_compare.bus_above_high_thresh,
                         bus_compare.bus_above_low_thresh};
      end else begin
        bus_snapshot[3] <= bus_compare.bus_sink_on;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      long_cnt <= 40'h00_0000_0000;
      wd_cnt <= 40'h00_0000_0000;
      long_timer_expired <= 1'b0;
      no_battery_test_done <= 1'b0;
      watchdog_expired <= 1'b0;
      status_mirror <= 4'h0;
    end else begin
      if (!long_timer_run | long_end) begin
        long_cnt <= 40'h00_0000_0000;
      end else if (!long_timer_disable & !long_timer_expired) begin
        long_cnt <= long_cnt + 40'h00_0000_0001;
      end
      wd_cnt <= (wd_restart | wd_end | watchdog_disable) ? 40'h00_0000_0000 :
                wd_cnt + 40'h00_0000_0001;
      watchdog_expired <= wd_end;
      // a set in the same cycle as a disconnect still lands
      if (long_end) begin
        long_timer_expired <= 1'b1;
      end else if (!bus_connected) begin
        long_timer_expired <= 1'b0;
      end
      if (no_battery_test_complete) begin
        no_battery_test_done <= 1'b1;
      end else if (!bus_connected) begin
        no_battery_test_done <= 1'b0;
      end
      status_mirror <= {charger_status.over_temp_flag, charger_status.foldback_temp_flag,
                        charger_status.charger_on_status,
                        charger_status.regulator_on_status};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 6'h00;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // read mux; reserved and write-only bits read zero
  wire [7:0] ctl_value = {bus_snapshot[3], probing, sense_select, probe_rate_select,
                          1'b0, bus_snapshot[2:0]};
  wire [7:0] ts_value = {status_mirror, no_battery_test_done, long_timer_expired,
                         long_timer_disable, watchdog_disable};

  wire rd_hit = (s_axi_araddr == attach_probe_pkg::ADDR_PROBE_CONTROL) |
                (s_axi_araddr == attach_probe_pkg::ADDR_PROBE_COUNT) |
                (s_axi_araddr == attach_probe_pkg::ADDR_TIMER_STATUS) |
                (s_axi_araddr == attach_probe_pkg::ADDR_IRQ_STATUS) |
                (s_axi_araddr == attach_probe_pkg::ADDR_IRQ_MASK);
  wire [7:0] rd_value =
    (s_axi_araddr == attach_probe_pkg::ADDR_PROBE_CONTROL) ? ctl_value :
    (s_axi_araddr == attach_probe_pkg::ADDR_PROBE_COUNT) ? probe_counter :
    (s_axi_araddr == attach_probe_pkg::ADDR_TIMER_STATUS) ? ts_value :
    (s_axi_araddr == attach_probe_pkg::ADDR_IRQ_STATUS) ? {2'b00, irq_status} :
    (s_axi_araddr == attach_probe_pkg::ADDR_IRQ_MASK) ? {2'b00, irq_mask} : 8'h00;

  // one write at a time; ready stays low until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= attach_probe_pkg::RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_fire) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? attach_probe_pkg::RESP_OKAY : attach_probe_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= attach_probe_pkg::RESP_OKAY;
    end else begin
      if (ar_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_value};
        s_axi_rresp <= rd_hit ? attach_probe_pkg::RESP_OKAY : attach_probe_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : attach_probe_timer_status_regs
`default_nettype wire

// [src/attach_probe_pkg.sv]
// Purpose: shared constants and types for the attach probe and timer status registers
// Assumes: 40 MHz core clock, AXI4-Lite register access with 32-bit data
// Notes: byte address of a register is four times its index
package attach_probe_pkg;

  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned ADDR_W = 8;

  // register indices and byte addresses
  localparam logic [7:0] IDX_PROBE_CONTROL = 8'h20;
  localparam logic [7:0] IDX_PROBE_COUNT = 8'h21;
  localparam logic [7:0] IDX_TIMER_STATUS = 8'h22;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h23;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h24;
  localparam logic [7:0] ADDR_PROBE_CONTROL = 8'(IDX_PROBE_CONTROL * 4);
  localparam logic [7:0] ADDR_PROBE_COUNT = 8'(IDX_PROBE_COUNT * 4);
  localparam logic [7:0] ADDR_TIMER_STATUS = 8'(IDX_TIMER_STATUS * 4);
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'(IDX_IRQ_STATUS * 4);
  localparam logic [7:0] ADDR_IRQ_MASK = 8'(IDX_IRQ_MASK * 4);

  // probe control fields
  localparam int unsigned CTL_SINK = 7;
  localparam int unsigned CTL_START = 6;
  localparam int unsigned CTL_SENSE = 5;
  localparam int unsigned CTL_RATE = 4;
  localparam int unsigned CTL_RESAMPLE = 3;
  localparam int unsigned CTL_REF_CMP = 2;
  localparam int unsigned CTL_HIGH = 1;
  localparam int unsigned CTL_LOW = 0;

  // timer and thermal fields
  localparam int unsigned TS_OVER_TEMP = 7;
  localparam int unsigned TS_FOLDBACK = 6;
  localparam int unsigned TS_CHARGER = 5;
  localparam int unsigned TS_REGULATOR = 4;
  localparam int unsigned TS_NO_BATTERY = 3;
  localparam int unsigned TS_LONG_EXPIRED = 2;
  localparam int unsigned TS_LONG_DISABLE = 1;
  localparam int unsigned TS_WD_DISABLE = 0;

  // interrupt status and mask fields
  localparam int unsigned IRQ_W = 6;
  localparam int unsigned IRQ_PROBE_DONE = 0;
  localparam int unsigned IRQ_PROBE_ERROR = 1;
  localparam int unsigned IRQ_RESAMPLE = 2;
  localparam int unsigned IRQ_SENSE = 3;
  localparam int unsigned IRQ_LONG_TIMER = 4;
  localparam int unsigned IRQ_WATCHDOG = 5;

  // reset values and the counter limit
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 6'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;

  // times in their own units and derived cycle counts
  localparam int unsigned TICK_FAST_US = 40;
  localparam int unsigned TICK_SLOW_US = 80;
  localparam int unsigned RESAMPLE_US = 1000;
  localparam longint unsigned LONG_TIMER_S = 1800;
  localparam longint unsigned WATCHDOG_S = 32;
  localparam logic [11:0] TICK_FAST_CYCLES = 12'(TICK_FAST_US * CLK_MHZ);
  localparam logic [11:0] TICK_SLOW_CYCLES = 12'(TICK_SLOW_US * CLK_MHZ);
  localparam int unsigned RESAMPLE_CYCLES = RESAMPLE_US * CLK_MHZ;
  localparam longint unsigned LONG_TIMER_CYCLES = LONG_TIMER_S * CLK_MHZ * 64'd1000000;
  localparam longint unsigned WATCHDOG_CYCLES = WATCHDOG_S * CLK_MHZ * 64'd1000000;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    PROBE_IDLE = 2'b01,
    PROBE_RUN = 2'b10
  } probe_state_t;

  typedef struct packed {
    logic bus_sink_on;
    logic bus_ref_compare;
    logic bus_above_high_thresh;
    logic bus_above_low_thresh;
  } bus_compare_t;

  typedef struct packed {
    logic over_temp_flag;
    logic foldback_temp_flag;
    logic charger_on_status;
    logic regulator_on_status;
  } charger_status_t;

endpackage : attach_probe_pkg

// [sim/attach_probe_props.sv]
// Purpose: port-level assertions for the probe and timer status register block
// Assumes: one aclk domain, aresetn synchronous and active low
// Notes: bound to every instance; bench keeps bready and rready high while waiting
`timescale 1ns/1ps
`default_nettype none
module attach_probe_props #(
  parameter int unsigned RESAMPLE_CYCLES = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic probe_source_on,
  input wire logic low_thresh_400mv,
  input wire logic resample_awake,
  input wire logic watchdog_expired
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // length of the awake window, cleared whenever it is closed
  logic [15:0] awake_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || !resample_awake) begin
      awake_cnt <= 16'h0;
    end else begin
      awake_cnt <= awake_cnt + 16'h1;
    end
  end
  property p_wresp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  property p_rresp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_rtop;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  property p_thresh;
    $changed(low_thresh_400mv) |-> $rose(s_axi_bvalid);
  endproperty
  property p_probe;
    $rose(probe_source_on) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  property p_awake;
    $fell(resample_awake) |-> awake_cnt == 16'(RESAMPLE_CYCLES);
  endproperty
  property p_wd;
    watchdog_expired |=> !watchdog_expired;
  endproperty
  a_wresp: assert property (p_wresp) else $error("write answer not two cycles late");
  a_rresp: assert property (p_rresp) else $error("read answer not one cycle late");
  a_busy: assert property (p_busy) else $error("ready high with response pending");
  a_rtop: assert property (p_rtop) else $error("read data upper bits set");
  a_thresh: assert property (p_thresh) else $error("threshold moved without write");
  a_probe: assert property (p_probe) else $error("probe started without write");
  a_awake: assert property (p_awake) else $error("awake window length wrong");
  a_wd: assert property (p_wd) else $error("watchdog pulse too long");
  c_awake: cover property ($fell(resample_awake));
  c_probe: cover property ($fell(probe_source_on));
  c_wd: cover property (watchdog_expired);
endmodule : attach_probe_props
bind attach_probe_timer_status_regs attach_probe_props #(.RESAMPLE_CYCLES(RESAMPLE_CYCLES)) u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .probe_source_on,
  .low_thresh_400mv, .resample_awake, .watchdog_expired);
`default_nettype wire

// [sim/tb.sv]
// Purpose: self-checking bench for the probe and timer status register block
// Assumes: short timer parameters; probe steps keep their full length
// Notes: the 255-step probe error run is left out, it would take 400k cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] A_CTL = attach_probe_pkg::ADDR_PROBE_CONTROL;
  localparam logic [7:0] A_CNT = attach_probe_pkg::ADDR_PROBE_COUNT;
  localparam logic [7:0] A_TS = attach_probe_pkg::ADDR_TIMER_STATUS;
  localparam logic [7:0] A_IS = attach_probe_pkg::ADDR_IRQ_STATUS;
  localparam logic [7:0] A_IM = attach_probe_pkg::ADDR_IRQ_MASK;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0;
  logic [7:0] s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  logic probe_source_on, low_thresh_400mv, resample_awake, watchdog_expired, irq;
  attach_probe_pkg::bus_compare_t bus_compare = 4'h0;
  attach_probe_pkg::charger_status_t charger_status = 4'h0;
  logic bus_connected = 1'h1, no_battery_test_complete = 1'h0;
  logic long_timer_run = 1'h0, watchdog_kick = 1'h0;
  int failures = 0;
  int samples_checked = 0;
  int wd_seen = 0;
  attach_probe_timer_status_regs #(.RESAMPLE_CYCLES(20), .LONG_TIMER_CYCLES(64'd50),
    .WATCHDOG_CYCLES(64'd60)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .bus_compare, .charger_status, .bus_connected, .no_battery_test_complete, .long_timer_run,
    .watchdog_kick, .probe_source_on, .low_thresh_400mv, .resample_awake, .watchdog_expired,
    .irq);
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (watchdog_expired === 1'h1) wd_seen++;
  end
  task automatic conclude();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'h1) begin
        aw_ok = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_ok && s_axi_wready === 1'h1) begin
        w_ok = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask : rdr
  // expected timer/thermal word from mirrored inputs and the low nibble
  function automatic logic [31:0] ts_word(input logic [3:0] lo);
    return {24'h0, charger_status, lo};
  endfunction : ts_word
  initial begin
    repeat (40000) @(posedge aclk);
    failures++;
    conclude();
  end
  initial begin
    void'($urandom(32'hc5f89a99));
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    charger_status <= 4'($urandom);
    @(posedge aclk);
    rdr(A_CNT);
    chk("count reset", 32'h0, rd);
    rdr(A_IM);
    chk("mask reset", 32'h0, rd);
    rdr(A_TS);
    chk("ts reset", ts_word(4'h0), rd);
    // disable both timers early, the short watchdog would fire during setup
    wr(A_TS, 8'hff);
    s_axi_wstrb <= 4'h0;
    wr(A_TS, 8'h00);
    s_axi_wstrb <= 4'hf;
    rdr(A_TS);
    chk("ts read-only", ts_word(4'h3), rd);
    wr(A_CNT, 8'h55);
    rdr(A_CNT);
    chk("count read-only", 32'h0, rd);
    wr(8'h40, 8'hff);
    chk("unmapped bresp", 32'h2, {30'h0, rs});
    rdr(8'h40);
    chk("unmapped rresp", 32'h2, {30'h0, rs});
    chk("unmapped rdata", 32'h0, rd);
    for (int i = 0; i < 6; i++) begin
      bus_compare <= 4'($urandom);
      charger_status <= 4'($urandom);
      repeat (3) @(posedge aclk);
      rdr(A_CTL);
      chk("sink bit", {31'h0, bus_compare.bus_sink_on}, {31'h0, rd[7]});
      rdr(A_TS);
      chk("ts mirror", ts_word(4'h3), rd);
    end
    for (int i = 0; i < 4; i++) begin
      wr(A_CTL, 8'(i << 4));
      chk("400mv select", 32'(i >> 1), {31'h0, low_thresh_400mv});
      rdr(A_CTL);
      chk("ctrl fields", {24'h0, bus_compare.bus_sink_on, 7'(i << 4)}, rd & 32'hf8);
    end
    bus_compare <= 4'h0;
    @(posedge aclk);
    bus_compare <= 4'h1;
    @(posedge aclk);
    rdr(A_IS);
    chk("sense event", 32'h8, rd);
    wr(A_IM, 8'h3f);
    wr(A_IS, 8'h3f);
    wr(A_CTL, 8'h08);
    for (int n = 0; n < 10 && resample_awake !== 1'h1; n++) @(posedge aclk);
    for (int n = 0; n < 100 && resample_awake === 1'h1; n++) @(posedge aclk);
    chk("irq on sleep", 32'h1, {31'h0, irq});
    rdr(A_IS);
    chk("resample status", 32'h4, rd);
    rdr(A_CTL);
    chk("cmp refresh", {29'h0, bus_compare[2:0]}, {29'h0, rd[2:0]});
    wr(A_IS, 8'h04);
    chk("irq cleared", 32'h0, {31'h0, irq});
    long_timer_run <= 1'h1;
    repeat (120) @(posedge aclk);
    rdr(A_TS);
    chk("long disabled", ts_word(4'h3), rd);
    wr(A_TS, 8'h01);
    repeat (120) @(posedge aclk);
    rdr(A_TS);
    chk("long expired", ts_word(4'h5), rd);
    long_timer_run <= 1'h0;
    no_battery_test_complete <= 1'h1;
    @(posedge aclk);
    no_battery_test_complete <= 1'h0;
    rdr(A_TS);
    chk("no battery", ts_word(4'hd), rd);
    bus_connected <= 1'h0;
    repeat (2) @(posedge aclk);
    bus_connected <= 1'h1;
    rdr(A_TS);
    chk("disconnect", ts_word(4'h1), rd);
    rdr(A_IS);
    chk("long status", 32'h10, rd);
    wr(A_IS, 8'h3f);
    wd_seen = 0;
    repeat (100) @(posedge aclk);
    chk("wd disabled", 32'h0, 32'(wd_seen));
    wr(A_TS, 8'h00);
    for (int i = 0; i < 4; i++) begin
      repeat (40) @(posedge aclk);
      watchdog_kick <= 1'h1;
      @(posedge aclk);
      watchdog_kick <= 1'h0;
    end
    chk("wd kicked", 32'h0, 32'(wd_seen));
    repeat (90) @(posedge aclk);
    chk("wd expired", 32'h1, 32'(wd_seen));
    wr(A_TS, 8'h01);
    rdr(A_IS);
    chk("wd status", 32'h20, rd);
    for (int r = 0; r < 2; r++) begin
      bus_compare <= 4'h0;
      wr(A_IS, 8'h3f);
      wr(A_CTL, 8'(8'h40 | (r << 4)));
      @(posedge aclk);
      chk("source on", 32'h1, {31'h0, probe_source_on});
      repeat (2 * 1600 * (r + 1) + 800 * (r + 1) + 800) @(posedge aclk);
      rdr(A_CNT);
      chk("count steps", 32'(3 - r), rd);
      rdr(A_CNT);
      chk("count cleared", 32'h0, rd);
      bus_compare <= 4'h2;
      repeat (3) @(posedge aclk);
      chk("source off", 32'h0, {31'h0, probe_source_on});
      rdr(A_CTL);
      chk("start self-clear", 32'h0, rd & 32'h40);
      rdr(A_IS);
      chk("probe done", 32'h1, rd);
    end
    conclude();
  end
endmodule : tb
`default_nettype wire
